// File: wdog_pkg.sv
`default_nettype none

package wdog_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_WDOG   = 8'hd8;
    localparam logic [7:0] ADDR_STATUS = 8'hd9;
    localparam logic [7:0] ADDR_CLEAR  = 8'hda;
    localparam logic [7:0] ADDR_ENABLE = 8'hdb;

    // ----------------------------------------------------------------
    // watchdog register fields
    // ----------------------------------------------------------------
    localparam int         ACT_BIT     = 0;
    localparam int         SR_BIT      = 1;
    localparam int         PERIOD_LO   = 2;
    localparam int         PERIOD_HI   = 7;
    localparam int         CNT_W       = 7;
    localparam int         CNT_TOP     = 6;
    localparam logic [7:0] WDOG_RESET  = 8'hfe;

    // ----------------------------------------------------------------
    // event status bits
    // ----------------------------------------------------------------
    localparam int         EV_W        = 4;
    localparam int         EV_ACTIVATE = 0;
    localparam int         EV_WRAP     = 1;
    localparam int         EV_STOP     = 2;
    localparam int         EV_WAIT     = 3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int         TICK_CYCLES = 3072;
    localparam int         MIN_INSTR   = 28;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_WAIT,
        PM_STOP
    } power_mode_e;

endpackage : wdog_pkg

`default_nettype wire

// File: wdog_sync.sv
`timescale 1ns/1ps
`default_nettype none

module wdog_sync #(
    parameter int WIDTH = 1
) (
    // clocking
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             clk_en,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("wdog_sync: WIDTH must be at least 1");
        end
    endgenerate

    // meta_q feeds only the second stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : wdog_sync

`default_nettype wire

// File: wdog_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module wdog_prescaler #(
    parameter int DIV = wdog_pkg::TICK_CYCLES
) (
    // clocking
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic clk_en,
    // control
    input  wire logic run,
    input  wire logic restart,
    // output
    output logic      tick
);

    localparam int PW = $clog2(DIV);

    logic [PW-1:0] div_q;

    generate
        if (DIV < 2) begin : g_chk
            $error("wdog_prescaler: DIV must be at least 2");
        end
    endgenerate

    // restart realigns the phase so a reload always gives a full period
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= '0;
            tick  <= 1'b0;
        end else if (clk_en) begin
            tick <= 1'b0;
            if (restart) begin
                div_q <= '0;
            end else if (run) begin
                if (div_q == PW'(DIV - 1)) begin
                    div_q <= '0;
                    tick  <= 1'b1;
                end else begin
                    div_q <= div_q + 1'b1;
                end
            end
        end
    end

endmodule : wdog_prescaler

`default_nettype wire

// File: wdog_core.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - active counter decrements, top-bit fall resets
// - software option: idle until activation bit set
// - activation cannot be undone except reset
// - inactive watchdog lets stop mode happen
// - hardware option: always active, stop acts wait
// - external control, nmi low: stop acts wait
// - external control, nmi high: freeze, enter stop
// - interrupt ends stop, counting resumes
// - reset value fe: inactive, longest period
// - soft reset bit falling triggers reset
// - period bits reversed against counter bits
// - counter bit six fall is timeout
// - 64 periods, 3072 to 196608 cycles
// - activation bit: hardware reads one, software sets
// - inactive: free 7-bit timer, no reset
// - 28 instructions after activation before reset
module wdog_core #(
    parameter int TICK_CYCLES = wdog_pkg::TICK_CYCLES,
    parameter int MIN_INSTR   = wdog_pkg::MIN_INSTR
) (
    // clocking
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    // option pins and nmi pin
    input  wire logic       opt_hw_activation,
    input  wire logic       opt_ext_stop,
    input  wire logic       nmi_pin,
    // core events
    input  wire logic       stop_instr,
    input  wire logic       wake_irq,
    input  wire logic       instr_done,
    // outputs
    output logic            mcu_reset,
    output logic            stop_mode,
    output logic            wait_mode,
    output logic            irq
);

    localparam int IC_W = $clog2(MIN_INSTR + 1);

    generate
        if (MIN_INSTR < 1) begin : g_chk
            $error("wdog_core: MIN_INSTR must be at least 1");
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic       hw_opt;
    logic       ext_opt;
    logic       nmi_s;

    wdog_sync #(
        .WIDTH    (3)
    ) u_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .clk_en   (clk_en),
        .async_in ({opt_hw_activation, opt_ext_stop, nmi_pin}),
        .sync_out (pins_s)
    );

    assign hw_opt  = pins_s[2];
    assign ext_opt = pins_s[1];
    assign nmi_s   = pins_s[0];

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic wr_wdog;
    logic wr_clear;
    logic wr_enable;

    assign wr_wdog   = wr_en && (addr == wdog_pkg::ADDR_WDOG);
    assign wr_clear  = wr_en && (addr == wdog_pkg::ADDR_CLEAR);
    assign wr_enable = wr_en && (addr == wdog_pkg::ADDR_ENABLE);

    // ----------------------------------------------------------------
    // activation
    // ----------------------------------------------------------------
    logic act_q;
    logic active;
    logic act_evt;

    // hardware option is active as soon as the strap is seen
    assign active  = hw_opt || act_q;
    assign act_evt = wr_wdog && wdata[wdog_pkg::ACT_BIT] && !active;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            act_q <= 1'b0;
        end else if (clk_en) begin
            // writes of zero are ignored, so once set it stays set
            if (wr_wdog && wdata[wdog_pkg::ACT_BIT] && !hw_opt) begin
                act_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // power mode
    // ----------------------------------------------------------------
    wdog_pkg::power_mode_e pm_q;
    logic                  frozen;

    assign frozen = (pm_q == wdog_pkg::PM_STOP);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pm_q <= wdog_pkg::PM_RUN;
        end else if (clk_en) begin
            unique case (pm_q)
                wdog_pkg::PM_RUN: begin
                    if (stop_instr) begin
                        if (!active) begin
                            pm_q <= wdog_pkg::PM_STOP;
                        end else if (ext_opt && nmi_s) begin
                            pm_q <= wdog_pkg::PM_STOP;
                        end else begin
                            pm_q <= wdog_pkg::PM_WAIT;
                        end
                    end
                end
                wdog_pkg::PM_WAIT: begin
                    if (wake_irq) begin
                        pm_q <= wdog_pkg::PM_RUN;
                    end
                end
                wdog_pkg::PM_STOP: begin
                    if (wake_irq) begin
                        pm_q <= wdog_pkg::PM_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stop_mode <= 1'b0;
            wait_mode <= 1'b0;
        end else if (clk_en) begin
            stop_mode <= (pm_q == wdog_pkg::PM_STOP);
            wait_mode <= (pm_q == wdog_pkg::PM_WAIT);
        end
    end

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    logic tick;

    // frozen while in stop: the oscillator would be halted there
    wdog_prescaler #(
        .DIV     (TICK_CYCLES)
    ) u_presc (
        .clock   (clock),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .run     (!frozen),
        .restart (wr_wdog),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // downcounter
    // ----------------------------------------------------------------
    logic [wdog_pkg::CNT_W-1:0] cnt_q;
    logic [wdog_pkg::CNT_W-1:0] cnt_d;
    logic [wdog_pkg::CNT_W-1:0] cnt_wr;
    logic                       top_fall;
    logic                       wrap_evt;

    // register bit 7 is counter bit 0, register bit 2 counter bit 5
    genvar gi;
    generate
        for (gi = 0; gi < wdog_pkg::CNT_TOP; gi++) begin : g_rev
            assign cnt_wr[gi] = wdata[wdog_pkg::PERIOD_HI - gi];
        end
    endgenerate
    assign cnt_wr[wdog_pkg::CNT_TOP] = wdata[wdog_pkg::SR_BIT];

    always_comb begin
        cnt_d = cnt_q;
        if (wr_wdog) begin
            cnt_d = cnt_wr;
        end else if (tick && !frozen) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // only bit six ends the period; bits 0..5 pick one of 64 lengths
    assign top_fall = cnt_q[wdog_pkg::CNT_TOP]
                   && !cnt_d[wdog_pkg::CNT_TOP];
    assign wrap_evt = !wr_wdog && tick && !frozen && (cnt_q == '0);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= wdog_pkg::WDOG_RESET[wdog_pkg::CNT_W:1];
        end else if (clk_en) begin
            // inactive: plain 7-bit timer that wraps at zero
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // instruction guard after activation
    // ----------------------------------------------------------------
    logic [IC_W-1:0] icnt_q;
    logic            guard_done;

    assign guard_done = (icnt_q == IC_W'(MIN_INSTR));

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            icnt_q <= '0;
        end else if (clk_en) begin
            if (!active) begin
                icnt_q <= '0;
            end else if (instr_done && !guard_done) begin
                icnt_q <= icnt_q + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // reset request
    // ----------------------------------------------------------------
    logic pend_q;

    // a fall inside the guard window is held, not dropped
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend_q    <= 1'b0;
            mcu_reset <= 1'b0;
        end else if (clk_en) begin
            if (active && top_fall) begin
                pend_q <= 1'b1;
            end
            if (guard_done && (pend_q || (active && top_fall))) begin
                mcu_reset <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // event status and interrupt
    // ----------------------------------------------------------------
    logic [wdog_pkg::EV_W-1:0] stat_q;
    logic [wdog_pkg::EV_W-1:0] en_q;
    logic [wdog_pkg::EV_W-1:0] ev_set;
    logic                      stop_evt;
    logic                      wait_evt;

    assign stop_evt = (pm_q == wdog_pkg::PM_RUN) && stop_instr
                   && (!active || (ext_opt && nmi_s));
    assign wait_evt = (pm_q == wdog_pkg::PM_RUN) && stop_instr && !stop_evt;

    always_comb begin
        ev_set                        = '0;
        ev_set[wdog_pkg::EV_ACTIVATE] = act_evt;
        ev_set[wdog_pkg::EV_WRAP]     = wrap_evt && !active;
        ev_set[wdog_pkg::EV_STOP]     = stop_evt;
        ev_set[wdog_pkg::EV_WAIT]     = wait_evt;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= '0;
        end else if (clk_en) begin
            // a new event beats a clear in the same cycle
            if (wr_clear) begin
                stat_q <= (stat_q & ~wdata[wdog_pkg::EV_W-1:0]) | ev_set;
            end else begin
                stat_q <= stat_q | ev_set;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= '0;
        end else if (clk_en && wr_enable) begin
            en_q <= wdata[wdog_pkg::EV_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(stat_q & en_q);
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    logic [7:0] wdog_rd;

    generate
        for (gi = 0; gi < wdog_pkg::CNT_TOP; gi++) begin : g_rd
            assign wdog_rd[wdog_pkg::PERIOD_HI - gi] = cnt_q[gi];
        end
    endgenerate
    assign wdog_rd[wdog_pkg::SR_BIT]  = cnt_q[wdog_pkg::CNT_TOP];
    assign wdog_rd[wdog_pkg::ACT_BIT] = active;

    // data stand for one cycle only, zero otherwise
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= '0;
        end else if (clk_en) begin
            rdata <= '0;
            if (rd_en) begin
                unique case (addr)
                    wdog_pkg::ADDR_WDOG:   rdata <= wdog_rd;
                    wdog_pkg::ADDR_STATUS: rdata <= {4'h0, stat_q};
                    wdog_pkg::ADDR_ENABLE: rdata <= {4'h0, en_q};
                    default:               rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule : wdog_core

`default_nettype wire

// File: wdog_core_chk.sv
`timescale 1ns/1ps
`default_nettype none

module wdog_core_chk #(
    parameter int TICK_CYCLES = wdog_pkg::TICK_CYCLES,
    parameter int MIN_INSTR   = wdog_pkg::MIN_INSTR
) (
    // clocking
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       clk_en,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    // options and core events
    input wire logic       opt_hw_activation,
    input wire logic       opt_ext_stop,
    input wire logic       nmi_pin,
    input wire logic       stop_instr,
    input wire logic       wake_irq,
    input wire logic       instr_done,
    // outputs
    input wire logic       mcu_reset,
    input wire logic       stop_mode,
    input wire logic       wait_mode,
    input wire logic       irq
);
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    logic [1:0] age_q;
    logic [3:0] nmi_q;
    logic       act_q;
    logic [7:0] ins_q;
    wire        ready  = (age_q == 2'h3);
    wire        act_wr = clk_en && wr_en && addr == wdog_pkg::ADDR_WDOG && wdata[0];

    // pins are synchronised, so mode decisions are only judged once they settled
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            age_q <= 2'h0;
            nmi_q <= 4'h0;
        end else if (clk_en) begin
            age_q <= ready ? age_q : age_q + 2'h1;
            nmi_q <= {nmi_q[2:0], nmi_pin};
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            act_q <= 1'b0;
            ins_q <= 8'h00;
        end else if (act_wr && !act_q && !opt_hw_activation) begin
            act_q <= 1'b1;
            ins_q <= 8'h00;
        end else if (clk_en && instr_done && ins_q != 8'hff) begin
            ins_q <= ins_q + 8'h01;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence s_stop_req;
        clk_en && stop_instr && !stop_mode && !wait_mode && !wake_irq && ready
        ##1 clk_en && !wake_irq;
    endsequence

    sequence s_wake;
        clk_en && wake_irq && (stop_mode || wait_mode) ##1 clk_en;
    endsequence

    a_reset_sticky: assert property (mcu_reset |=> mcu_reset)
        else $error("watchdog reset dropped");
    a_rdata_idle: assert property (clk_en && !rd_en |=> rdata == 8'h00)
        else $error("read data outside read cycle");
    a_act_reads: assert property (clk_en && rd_en && addr == wdog_pkg::ADDR_WDOG
        && (opt_hw_activation || act_q) && ready |=> rdata[0])
        else $error("activation bit reads zero while active");
    a_idle_quiet: assert property (!opt_hw_activation && !act_q && ready |=> !mcu_reset)
        else $error("reset while watchdog inactive");
    a_min_instr: assert property ($rose(mcu_reset) |-> ins_q >= MIN_INSTR)
        else $error("reset before enough instructions");
    a_idle_stop: assert property ((!opt_hw_activation && !act_q) ##0 s_stop_req
        |-> ##1 (stop_mode && !wait_mode))
        else $error("inactive watchdog did not allow stop");
    a_hw_wait: assert property ((opt_hw_activation && !opt_ext_stop) ##0 s_stop_req
        |-> ##1 (wait_mode && !stop_mode))
        else $error("hardware option did not turn stop into wait");
    a_nmi_wait: assert property ((opt_hw_activation && opt_ext_stop && !nmi_pin
        && nmi_q == 4'h0) ##0 s_stop_req |-> ##1 (wait_mode && !stop_mode))
        else $error("low nmi did not give wait");
    a_nmi_stop: assert property ((opt_hw_activation && opt_ext_stop && nmi_pin
        && nmi_q == 4'hf) ##0 s_stop_req |-> ##1 (stop_mode && !wait_mode))
        else $error("high nmi did not give stop");
    a_wake_resume: assert property (s_wake |-> ##1 !(stop_mode || wait_mode))
        else $error("interrupt did not end low power mode");
endmodule : wdog_core_chk

bind wdog_core wdog_core_chk #(.TICK_CYCLES(TICK_CYCLES), .MIN_INSTR(MIN_INSTR)) u_wdog_core_chk (
    .clock(clock), .arst_n(arst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .opt_hw_activation(opt_hw_activation),
    .opt_ext_stop(opt_ext_stop), .nmi_pin(nmi_pin), .stop_instr(stop_instr),
    .wake_irq(wake_irq), .instr_done(instr_done), .mcu_reset(mcu_reset),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .irq(irq)
);

`default_nettype wire

// File: digital_watchdog_downcounter_bench.sv
`timescale 1ns/1ps
`default_nettype none

module digital_watchdog_downcounter_bench;
    // short counts keep the run brief; expectations follow these values
    localparam int         TICK     = 4;
    localparam int         MINI     = 2;
    localparam logic [7:0] REG_WDOG = wdog_pkg::ADDR_WDOG;
    localparam logic [7:0] REG_STAT = wdog_pkg::ADDR_STATUS;
    localparam logic [7:0] REG_CLR  = wdog_pkg::ADDR_CLEAR;
    localparam logic [7:0] REG_EN   = wdog_pkg::ADDR_ENABLE;

    logic       clock             = 1'b0;
    logic       arst_n            = 1'b0;
    logic       clk_en            = 1'b1;
    logic [7:0] addr              = 8'h00;
    logic [7:0] wdata             = 8'h00;
    logic       wr_en             = 1'b0;
    logic       rd_en             = 1'b0;
    logic       opt_hw_activation = 1'b0;
    logic       opt_ext_stop      = 1'b0;
    logic       nmi_pin           = 1'b0;
    logic       stop_instr        = 1'b0;
    logic       wake_irq          = 1'b0;
    logic       instr_done        = 1'b0;
    logic [7:0] rdata;
    logic       mcu_reset;
    logic       stop_mode;
    logic       wait_mode;
    logic       irq;
    int         fails             = 0;
    int         checks            = 0;

    wdog_core #(.TICK_CYCLES(TICK), .MIN_INSTR(MINI)) u_wdog_core (
        .clock(clock), .arst_n(arst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .opt_hw_activation(opt_hw_activation),
        .opt_ext_stop(opt_ext_stop), .nmi_pin(nmi_pin), .stop_instr(stop_instr),
        .wake_irq(wake_irq), .instr_done(instr_done), .mcu_reset(mcu_reset),
        .stop_mode(stop_mode), .wait_mode(wait_mode), .irq(irq)
    );

    initial begin
        forever #2.5 clock = ~clock;
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one-cycle strobe: a second sampled edge would write twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        addr  <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        addr  <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk(name, rdata, exp);
    endtask : rchk

    task automatic ev(input logic s, input logic w, input logic i);
        @(posedge clock);
        wr_en      <= 1'b0;
        stop_instr <= s;
        wake_irq   <= w;
        instr_done <= i;
        @(posedge clock);
        stop_instr <= 1'b0;
        wake_irq   <= 1'b0;
        instr_done <= 1'b0;
    endtask : ev

    task automatic cyc(input int n);
        @(posedge clock);
        wr_en <= 1'b0;
        repeat (n - 1) @(posedge clock);
        #1;
    endtask : cyc

    task automatic do_reset(input logic hw, input logic ext);
        @(posedge clock);
        arst_n            <= 1'b0;
        opt_hw_activation <= hw;
        opt_ext_stop      <= ext;
        nmi_pin           <= 1'b0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        cyc(3);
    endtask : do_reset

    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        #200000;
        fails++;
        wrap_up();
    end

    initial begin
        // software option: timer mode, register map, events
        do_reset(1'b0, 1'b0);
        rchk("reset value", REG_WDOG, 8'hfe);
        rchk("unmapped", 8'h00, 8'h00);
        rchk("clear reads", REG_CLR, 8'h00);
        wr(REG_WDOG, 8'h86);
        rchk("reload", REG_WDOG, 8'h86);
        cyc(3);
        rchk("one tick", REG_WDOG, 8'h06);
        wr(REG_WDOG, 8'h02);
        cyc(6);
        chk("timer no reset", {7'h00, mcu_reset}, 8'h00);
        rchk("timer top fall", REG_WDOG, 8'hfc);
        wr(REG_WDOG, 8'h00);
        cyc(6);
        rchk("wrap status", REG_STAT, 8'h02);
        chk("irq masked", {7'h00, irq}, 8'h00);
        wr(REG_EN, 8'h02);
        cyc(3);
        chk("irq raised", {7'h00, irq}, 8'h01);
        rchk("enable", REG_EN, 8'h02);
        wr(REG_CLR, 8'h02);
        cyc(3);
        chk("irq cleared", {7'h00, irq}, 8'h00);
        rchk("status cleared", REG_STAT, 8'h00);
        ev(1'b1, 1'b0, 1'b0);
        cyc(2);
        chk("idle stop", {7'h00, stop_mode}, 8'h01);
        ev(1'b0, 1'b1, 1'b0);
        cyc(2);
        chk("idle wake", {7'h00, stop_mode}, 8'h00);
        wr(REG_WDOG, 8'h86);
        @(posedge clock) clk_en <= 1'b0;
        cyc(10);
        @(posedge clock) clk_en <= 1'b1;
        rchk("enable freeze", REG_WDOG, 8'h86);

        // software activation, no way back, soft reset bit
        do_reset(1'b0, 1'b0);
        rchk("idle after reset", REG_WDOG, 8'hfe);
        wr(REG_WDOG, 8'hff);
        rchk("activated", REG_WDOG, 8'hff);
        wr(REG_WDOG, 8'hfe);
        rchk("stays active", REG_WDOG, 8'hff);
        rchk("act status", REG_STAT, 8'h01);
        wr(REG_WDOG, 8'hfd);
        cyc(4);
        chk("early reset", {7'h00, mcu_reset}, 8'h00);
        ev(1'b0, 1'b0, 1'b1);
        ev(1'b0, 1'b0, 1'b1);
        cyc(2);
        chk("soft reset", {7'h00, mcu_reset}, 8'h01);

        // hardware option: stop acts as wait, timeout
        do_reset(1'b1, 1'b0);
        rchk("hw reset value", REG_WDOG, 8'hff);
        ev(1'b1, 1'b0, 1'b0);
        cyc(2);
        chk("hw wait", {6'h00, stop_mode, wait_mode}, 8'h01);
        rchk("wait status", REG_STAT, 8'h08);
        ev(1'b0, 1'b1, 1'b0);
        cyc(2);
        chk("hw wake", {7'h00, wait_mode}, 8'h00);
        ev(1'b0, 1'b0, 1'b1);
        ev(1'b0, 1'b0, 1'b1);
        wr(REG_WDOG, 8'h82);
        cyc(5);
        chk("before timeout", {7'h00, mcu_reset}, 8'h00);
        cyc(7);
        chk("timeout", {7'h00, mcu_reset}, 8'h01);

        // external stop control by the nmi level
        do_reset(1'b1, 1'b1);
        ev(1'b1, 1'b0, 1'b0);
        cyc(2);
        chk("nmi low wait", {6'h00, stop_mode, wait_mode}, 8'h01);
        ev(1'b0, 1'b1, 1'b0);
        @(posedge clock) nmi_pin <= 1'b1;
        cyc(4);
        wr(REG_WDOG, 8'hfe);
        ev(1'b1, 1'b0, 1'b0);
        cyc(12);
        chk("nmi high stop", {6'h00, stop_mode, wait_mode}, 8'h02);
        rchk("frozen", REG_WDOG, 8'hff);
        ev(1'b0, 1'b1, 1'b0);
        cyc(2);
        chk("stop wake", {7'h00, stop_mode}, 8'h00);
        wrap_up();
    end
endmodule : digital_watchdog_downcounter_bench

`default_nettype wire
